// ==== rtl/changeover_pkg.sv ====
`default_nettype none
package changeover_pkg;
	// channel layout: alarm channels are a contiguous span of the channels
	localparam int NUM_CH = 11;
	localparam int ALM_FIRST = 3;
	localparam int ALM_LAST = 11;
	localparam int NUM_ALM = ALM_LAST - ALM_FIRST + 1;
	localparam int NUM_REMOTE = 3;

	// remote input positions in the synchronised vector
	localparam int RIN_AUTO = 0;
	localparam int RIN_SRC = 1;
	localparam int RIN_RST = 2;

	// timing, figures in milliseconds, counts derived from the clock rate
	localparam int CLK_HZ = 40_000_000;
	localparam int DEBOUNCE_MS = 10;
	localparam int BLINK_HALF_MS = 250;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);

	// apb register byte offsets
	localparam logic [7:0] NET_CFG_OFS = 8'h00;
	localparam logic [7:0] CMD_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] FAULTS_OFS = 8'h0c;
	localparam logic [7:0] ALARMS_OFS = 8'h10;

	// field positions
	localparam int CFG_MODE_BIT = 0;
	localparam int CFG_IND_BIT = 1;
	localparam int CMD_RESET_BIT = 0;
	localparam int ST_AUTH_BIT = 0;
	localparam int ST_SPARE_BIT = 1;
	localparam int ST_TROUBLE_BIT = 2;
	localparam int ST_AUTO_BIT = 3;
	localparam int ST_PWR_BIT = 4;
	localparam int FLT_SPARE_POS = 16;

	// settings that either the panel switches or the network supply
	typedef struct packed {
		logic out_alarm_ind; // 1: per-channel output alarms shown
		logic fault_alarm_mode; // 1: fault plus alarm, 0: fault only
	} cfg_s;

	localparam cfg_s NET_CFG_RST = '{out_alarm_ind: 1'b1,
		fault_alarm_mode: 1'b0};

	typedef enum logic [1:0] {
		AUTH_PANEL = 2'b01,
		AUTH_NET = 2'b10
	} auth_e;

	typedef enum logic [1:0] {
		SRC_MAIN = 2'b01,
		SRC_SPARE = 2'b10
	} src_e;
endpackage
`default_nettype wire

// ==== rtl/changeover_control_fault_latch.sv ====
// Function
// RULE1: configuration from panel or network per authority
// RULE2: authority key toggles panel and network
// RULE3: network settings restored on return to network
// RULE4: authority resets to panel
// RULE5: fault lamp lit per faulted channel
// RULE6: feed summary lamp blinks on feed fault
// RULE7: fault lamps stay latched until reset
// RULE8: reset clears all latched indications
// RULE9: alarm lamps only channels three to eleven
// RULE10: alarmed channel bypasses its amplifier
// RULE11: indication switch off darkens alarm lamps
// RULE12: power lamp on error or supply off
// RULE13: remote low disables auto switching
// RULE14: panel auto off ignores remote input
// RULE15: each remote low toggles source once
// RULE16: status outputs show selected feed
// RULE17: fault-only mode flags any feed fault
// RULE18: fault-plus-alarm mode also flags alarms
// RULE19: trouble flag sticky until reset
// RULE20: remote party drives reset low
// RULE21: isolated contact conducts like trouble flag
// RULE22: indication off keeps channel alarms from flag
// RULE23: auto switching leaves faulted output feed
// RULE24: selected source resets to main
// RULE25: remote inputs synchronised, debounced, edge driven
`default_nettype none
module changeover_control_fault_latch #(
	parameter int DEBOUNCE_CYC = changeover_pkg::DEBOUNCE_CYC,
	parameter int BLINK_HALF_CYC = changeover_pkg::BLINK_HALF_CYC
) (
	input wire logic clock, // 40 mhz system clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire changeover_pkg::cfg_s panel_cfg, // top-panel switch bank
	input wire logic auth_key, // authority key press, one pulse
	input wire logic src_key, // source key press, one pulse
	input wire logic reset_key, // reset key press, one pulse
	input wire logic panel_auto_en, // panel auto-switch setting
	input wire logic [10:0] main_fault, // main feed fault detectors
	input wire logic [10:0] spare_fault, // spare feed fault detectors
	input wire logic [8:0] out_err, // output errors, channels 3..11
	input wire logic psu_err, // supply output error
	input wire logic [1:0] psu_on, // supply on, one per supply
	input wire logic remote_auto_n, // remote auto-switch disable, low
	input wire logic remote_src_n, // remote source toggle, low
	input wire logic remote_rst_n, // remote reset, low
	output changeover_pkg::cfg_s active_cfg, // configuration in force
	output logic auth_net_lamp, // high while network authority
	output logic [10:0] main_fault_lamp, // per-channel main fault lamps
	output logic [10:0] spare_fault_lamp, // per-channel spare lamps
	output logic main_sum_lamp, // blinking main summary lamp
	output logic spare_sum_lamp, // blinking spare summary lamp
	output logic [8:0] alarm_lamp, // output alarm lamps, ch 3..11
	output logic [8:0] amp_bypass, // route input straight to output
	output logic power_lamp, // power alarm lamp
	output logic [1:0] psu_off_lamp, // lamp of a supply that is off
	output logic auto_active, // automatic switching in effect
	output logic main_sel, // high while main feed selected
	output logic spare_sel, // high while spare feed selected
	output logic summary_trouble_flag, // sticky trouble output
	output logic trouble_contact_on // isolated contact pair conducts
);
	localparam int DCW = $clog2(DEBOUNCE_CYC + 1);
	localparam int BCW = $clog2(BLINK_HALF_CYC + 1);
	localparam int NR = changeover_pkg::NUM_REMOTE;

	changeover_pkg::auth_e auth_q;
	changeover_pkg::src_e src_q;
	changeover_pkg::cfg_s net_cfg_q;
	logic [NR-1:0] sync1_q, sync2_q, stable_q, stable_prev_q;
	logic [10:0] main_lat_q, spare_lat_q;
	logic [8:0] alm_lat_q;
	logic trouble_q;
	logic [BCW-1:0] blink_cnt_q;
	logic blink_q;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic wr_en, cmd_reset, clear_all, remote_src_fall, remote_rst_fall;
	logic auto_en, main_any, spare_any, auto_swap, manual_swap;
	logic pwr_alarm, alarm_any, trouble_set, addr_ok;
	logic [31:0] rd_word;

	//////////////////////////////////////////////////////////////////////
	// remote connector inputs: two-flop synchroniser, then debounce

	// open pins pull high, so idle levels are one
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sync1_q <= '1;
			sync2_q <= '1;
		end else begin
			sync1_q <= {remote_rst_n, remote_src_n, remote_auto_n}; // [RULE25]
			sync2_q <= sync1_q;
		end
	end

	// a level must hold a full debounce time before it is believed
	for (genvar i = 0; i < NR; i++) begin : g_deb
		logic [DCW-1:0] cnt_q;
		always_ff @(posedge clock) begin
			if (sys_rst) begin
				cnt_q <= '0;
				stable_q[i] <= 1'b1;
			end else if (sync2_q[i] == stable_q[i]) begin
				cnt_q <= '0;
			end else if (cnt_q == DCW'(DEBOUNCE_CYC - 1)) begin
				cnt_q <= '0;
				stable_q[i] <= sync2_q[i]; // [RULE25]
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// previous debounced level for edge detection
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			stable_prev_q <= '1;
		end else begin
			stable_prev_q <= stable_q;
		end
	end

	// one pulse per new low application
	assign remote_src_fall = stable_prev_q[changeover_pkg::RIN_SRC] &
		~stable_q[changeover_pkg::RIN_SRC]; // [RULE15] [RULE25]
	assign remote_rst_fall = stable_prev_q[changeover_pkg::RIN_RST] &
		~stable_q[changeover_pkg::RIN_RST]; // [RULE20]

	//////////////////////////////////////////////////////////////////////
	// apb slave: one wait state so read data comes from a flip-flop

	assign addr_ok = (paddr == changeover_pkg::NET_CFG_OFS) ||
		(paddr == changeover_pkg::CMD_OFS) ||
		(paddr == changeover_pkg::STATUS_OFS) ||
		(paddr == changeover_pkg::FAULTS_OFS) ||
		(paddr == changeover_pkg::ALARMS_OFS);

	// read mux; unmapped and write-only words read zero
	always_comb begin
		rd_word = '0;
		case (paddr)
			changeover_pkg::NET_CFG_OFS: begin
				rd_word[changeover_pkg::CFG_MODE_BIT] =
					net_cfg_q.fault_alarm_mode;
				rd_word[changeover_pkg::CFG_IND_BIT] = net_cfg_q.out_alarm_ind;
			end
			changeover_pkg::STATUS_OFS: begin
				rd_word[changeover_pkg::ST_AUTH_BIT] =
					(auth_q == changeover_pkg::AUTH_NET);
				rd_word[changeover_pkg::ST_SPARE_BIT] =
					(src_q == changeover_pkg::SRC_SPARE);
				rd_word[changeover_pkg::ST_TROUBLE_BIT] = trouble_q;
				rd_word[changeover_pkg::ST_AUTO_BIT] = auto_en;
				rd_word[changeover_pkg::ST_PWR_BIT] = pwr_alarm;
			end
			changeover_pkg::FAULTS_OFS: begin
				rd_word[10:0] = main_lat_q;
				rd_word[changeover_pkg::FLT_SPARE_POS +: 11] = spare_lat_q;
			end
			changeover_pkg::ALARMS_OFS: begin
				rd_word[8:0] = alm_lat_q;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// ready rises in the second access cycle with data and error captured
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			if (psel & penable & ~pready_q) begin
				pslverr_q <= ~addr_ok;
				prdata_q <= pwrite ? '0 : rd_word;
			end
		end
	end

	assign pready = pready_q;
	assign pslverr = pready_q & pslverr_q;
	assign prdata = prdata_q;
	assign wr_en = psel & penable & pready_q & pwrite & addr_ok;
	assign cmd_reset = wr_en & (paddr == changeover_pkg::CMD_OFS) &
		pwdata[changeover_pkg::CMD_RESET_BIT];

	// network settings keep their value across authority changes; writes land under either
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			net_cfg_q <= changeover_pkg::NET_CFG_RST;
		end else if (wr_en && paddr == changeover_pkg::NET_CFG_OFS) begin
			net_cfg_q.fault_alarm_mode <= pwdata[changeover_pkg::CFG_MODE_BIT];
			net_cfg_q.out_alarm_ind <= pwdata[changeover_pkg::CFG_IND_BIT];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// configuration authority

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			auth_q <= changeover_pkg::AUTH_PANEL; // [RULE4]
		end else if (auth_key) begin
			case (auth_q) // [RULE2]
				changeover_pkg::AUTH_PANEL: auth_q <= changeover_pkg::AUTH_NET;
				changeover_pkg::AUTH_NET: auth_q <= changeover_pkg::AUTH_PANEL;
				default: auth_q <= changeover_pkg::AUTH_PANEL;
			endcase
		end
	end

	// stored network values come back untouched on the switch over
	assign active_cfg = (auth_q == changeover_pkg::AUTH_NET) ?
		net_cfg_q : panel_cfg; // [RULE1] [RULE3]
	assign auth_net_lamp = (auth_q == changeover_pkg::AUTH_NET);

	//////////////////////////////////////////////////////////////////////
	// source selection

	assign auto_en = panel_auto_en &
		stable_q[changeover_pkg::RIN_AUTO]; // [RULE13] [RULE14]
	assign auto_active = auto_en;
	assign main_any = |main_fault;
	assign spare_any = |spare_fault;
	// a fault on both feeds gives nothing better to switch to
	assign auto_swap = auto_en & (src_q == changeover_pkg::SRC_MAIN ?
		(main_any & ~spare_any) : (spare_any & ~main_any)); // [RULE23]
	assign manual_swap = src_key | remote_src_fall; // [RULE15]

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			src_q <= changeover_pkg::SRC_MAIN; // [RULE24]
		end else if (manual_swap | auto_swap) begin
			case (src_q)
				changeover_pkg::SRC_MAIN: src_q <= changeover_pkg::SRC_SPARE;
				changeover_pkg::SRC_SPARE: src_q <= changeover_pkg::SRC_MAIN;
				default: src_q <= changeover_pkg::SRC_MAIN;
			endcase
		end
	end

	assign main_sel = (src_q == changeover_pkg::SRC_MAIN); // [RULE16]
	assign spare_sel = (src_q == changeover_pkg::SRC_SPARE); // [RULE16]

	//////////////////////////////////////////////////////////////////////
	// latched indications; a new event in a clearing cycle still lands

	assign clear_all = reset_key | remote_rst_fall | cmd_reset; // [RULE8]

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			main_lat_q <= '0;
			spare_lat_q <= '0;
			alm_lat_q <= '0;
		end else begin
			main_lat_q <= (clear_all ? '0 : main_lat_q) | main_fault; // [RULE7]
			spare_lat_q <= (clear_all ? '0 : spare_lat_q) | spare_fault;
			alm_lat_q <= (clear_all ? '0 : alm_lat_q) | out_err; // [RULE9]
		end
	end

	assign main_fault_lamp = main_lat_q; // [RULE5]
	assign spare_fault_lamp = spare_lat_q; // [RULE5]
	assign alarm_lamp = active_cfg.out_alarm_ind ? alm_lat_q : '0; // [RULE11]
	// bypass does not depend on the lamp mask: the path is still bad
	assign amp_bypass = alm_lat_q; // [RULE10]

	// live supply state; a supply that is off is not a latched event
	assign pwr_alarm = psu_err | ~(&psu_on); // [RULE12]
	assign power_lamp = pwr_alarm;
	assign psu_off_lamp = ~psu_on; // [RULE12]

	// summary blink clock shared by both feed lamps
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			blink_cnt_q <= '0;
			blink_q <= 1'b0;
		end else if (blink_cnt_q == BCW'(BLINK_HALF_CYC - 1)) begin
			blink_cnt_q <= '0;
			blink_q <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 1'b1;
		end
	end

	assign main_sum_lamp = (|main_lat_q) & blink_q; // [RULE6]
	assign spare_sum_lamp = (|spare_lat_q) & blink_q; // [RULE6]

	//////////////////////////////////////////////////////////////////////
	// summary trouble flag and isolated contact

	assign alarm_any = (active_cfg.out_alarm_ind & (|out_err)) |
		pwr_alarm; // [RULE22]
	assign trouble_set = main_any | spare_any | // [RULE17]
		(active_cfg.fault_alarm_mode & alarm_any); // [RULE18]

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			trouble_q <= 1'b0;
		end else begin
			trouble_q <= (trouble_q & ~clear_all) | trouble_set; // [RULE19]
		end
	end

	assign summary_trouble_flag = trouble_q;
	assign trouble_contact_on = trouble_q; // [RULE21]

	//////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_auth_press;
		auth_key ##1 1'b1;
	endsequence

	a_auth_toggle: assert property (auth_key |=> // [RULE2]
		auth_net_lamp != $past(auth_net_lamp))
		else $error("authority did not toggle");
	a_auth_default: assert property ($fell(sys_rst) |-> // [RULE4]
		!auth_net_lamp && main_sel)
		else $error("authority or source not at default");
	a_cfg_select: assert property (!auth_net_lamp |-> // [RULE1]
		active_cfg == panel_cfg)
		else $error("panel settings not in force");
	a_net_restore: assert property (!auth_net_lamp ##0 s_auth_press |-> // [RULE3]
		active_cfg == net_cfg_q)
		else $error("network settings not restored");
	a_fault_latch: assert property (main_fault[0] && !clear_all ##1 // [RULE7]
		!clear_all [*3] |-> main_fault_lamp[0])
		else $error("fault lamp dropped before reset");
	a_reset_clear: assert property (clear_all && !main_any && !spare_any && // [RULE8]
		out_err == '0 && !pwr_alarm |=> main_fault_lamp == '0 &&
		spare_fault_lamp == '0 && !summary_trouble_flag)
		else $error("reset left an indication lit");
	a_alarm_mask: assert property (!active_cfg.out_alarm_ind |-> // [RULE11]
		alarm_lamp == '0)
		else $error("alarm lamp lit while masked");
	a_bypass_err: assert property (out_err[4] |=> amp_bypass[4]) // [RULE10]
		else $error("alarmed channel not bypassed");
	a_power_lamp: assert property (!psu_on[1] |-> // [RULE12]
		power_lamp && psu_off_lamp[1])
		else $error("power lamp dark with supply off");
	a_src_status: assert property (main_sel != spare_sel) // [RULE16]
		else $error("source status outputs inconsistent");
	a_trouble_set: assert property (main_any |=> summary_trouble_flag) // [RULE17]
		else $error("trouble flag missed a fault");
	a_trouble_hold: assert property (summary_trouble_flag && !clear_all // [RULE19]
		|=> summary_trouble_flag)
		else $error("trouble flag dropped without reset");
	a_contact_same: assert property (trouble_contact_on == // [RULE21]
		summary_trouble_flag)
		else $error("contact differs from trouble flag");
	a_auto_ignore: assert property (!panel_auto_en && !manual_swap |=> // [RULE14]
		$stable(src_q))
		else $error("source changed with auto switching off");
	a_auto_switch: assert property (auto_en && main_sel && main_any && // [RULE23]
		!spare_any && !manual_swap |=> spare_sel)
		else $error("auto switch did not leave faulted feed");
	a_remote_edge: assert property (remote_src_fall && !src_key && // [RULE15]
		!auto_swap |=> main_sel != $past(main_sel))
		else $error("remote select did not toggle once");
	a_remote_auto: assert property (panel_auto_en && // [RULE13]
		!stable_q[changeover_pkg::RIN_AUTO] |-> !auto_active)
		else $error("remote low did not disable auto");
endmodule
`default_nettype wire

// ==== test/remote_panel.sv ====
`default_nettype none
// remote panel: each switch pulls its pin to ground, a pull-up holds it high
module remote_panel (
	input wire logic auto_off, // auto-switch disable switch closed
	input wire logic src_on, // source toggle switch closed
	input wire logic rst_on, // reset switch closed
	output logic remote_auto_n, // auto-switch pin
	output logic remote_src_n, // source pin
	output logic remote_rst_n // reset pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// an open switch leaves the pull-up level, never a stale value
	assign remote_auto_n = !auto_off;
	assign remote_src_n = !src_on;
	assign remote_rst_n = !rst_on;
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [10:0] mf;
		logic [10:0] sf;
		logic [8:0] oe;
		logic [1:0] pon;
		logic perr;
		logic [1:0] cfg;
		logic tr;
	} row_s;
	// fault and alarm cases: inputs, then the trouble flag they leave
	localparam row_s ROWS [7] = '{
		'{11'h001, 11'h000, 9'h000, 2'h3, 1'b0, 2'h2, 1'b1},
		'{11'h000, 11'h002, 9'h000, 2'h3, 1'b0, 2'h0, 1'b1},
		'{11'h000, 11'h000, 9'h001, 2'h3, 1'b0, 2'h3, 1'b1},
		'{11'h000, 11'h000, 9'h100, 2'h3, 1'b0, 2'h1, 1'b0},
		'{11'h000, 11'h000, 9'h000, 2'h3, 1'b1, 2'h1, 1'b1},
		'{11'h000, 11'h000, 9'h000, 2'h1, 1'b0, 2'h2, 1'b0},
		'{11'h000, 11'h000, 9'h1ff, 2'h3, 1'b0, 2'h2, 1'b0}
	};
	localparam row_s NORM = '{11'h0, 11'h0, 9'h0, 2'h3, 1'b0, 2'h2, 1'b0};
	// short counts keep debounce and blink inside the run
	localparam int DB = 4;
	localparam int BH = 8;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, exp_w;
	logic pready, pslverr, er;
	changeover_pkg::cfg_s panel_cfg = 2'h2, active_cfg;
	logic [2:0] keys = 3'h0;
	logic panel_auto_en = 1'b0, perr = 1'b0;
	logic [10:0] mf = 11'h0, sf = 11'h0, mfl, sfl;
	logic [8:0] oe = 9'h0, alarm_lamp, amp_bypass;
	logic [1:0] pon = 2'h3, psu_off_lamp;
	logic auto_off = 1'b0, src_on = 1'b0, rst_on = 1'b0;
	logic ra_n, rs_n, rr_n, auth_net_lamp, main_sum_lamp, spare_sum_lamp;
	logic power_lamp, auto_active, main_sel, spare_sel, flag, contact;
	int bad_count = 0, tests_run = 0, cyc = 0, hi;
	row_s r;

	////////////////////////////////////////////////////////////////////////
	// keys: bit 0 authority, bit 1 source, bit 2 reset
	changeover_control_fault_latch #(.DEBOUNCE_CYC(DB), .BLINK_HALF_CYC(BH))
		changeover_control_fault_latch_inst (
		.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .panel_cfg(panel_cfg),
		.auth_key(keys[0]), .src_key(keys[1]), .reset_key(keys[2]),
		.panel_auto_en(panel_auto_en), .main_fault(mf), .spare_fault(sf),
		.out_err(oe), .psu_err(perr), .psu_on(pon), .remote_auto_n(ra_n),
		.remote_src_n(rs_n), .remote_rst_n(rr_n), .active_cfg(active_cfg),
		.auth_net_lamp(auth_net_lamp), .main_fault_lamp(mfl),
		.spare_fault_lamp(sfl), .main_sum_lamp(main_sum_lamp),
		.spare_sum_lamp(spare_sum_lamp), .alarm_lamp(alarm_lamp),
		.amp_bypass(amp_bypass), .power_lamp(power_lamp),
		.psu_off_lamp(psu_off_lamp), .auto_active(auto_active),
		.main_sel(main_sel), .spare_sel(spare_sel),
		.summary_trouble_flag(flag), .trouble_contact_on(contact));
	remote_panel remote_panel_inst (.auto_off(auto_off), .src_on(src_on),
		.rst_on(rst_on), .remote_auto_n(ra_n), .remote_src_n(rs_n),
		.remote_rst_n(rr_n));

	////////////////////////////////////////////////////////////////////////
	// 40 mhz clock
	initial begin
		forever #12.5 clock = ~clock;
	end

	// run ceiling, far above the length of the sequence
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			print_verdict();
		end
	end

	task tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask

	// one key pulse, then room for its effect to land
	task press(input int k);
		keys <= 3'(1 << k);
		tick(1);
		keys <= 3'h0;
		tick(2);
	endtask

	task drive(input row_s v);
		mf <= v.mf;
		sf <= v.sf;
		oe <= v.oe;
		pon <= v.pon;
		perr <= v.perr;
	endtask

	// apb master: request held until pready is seen high at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task print_verdict();
		$display("mismatches %0d, checks %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		tick(8);
		sys_rst <= 1'b0;
		tick(2);
		// values left by reset
		chk(auth_net_lamp, 1'b0);
		chk({main_sel, spare_sel}, 2'b10);
		chk(flag, 1'b0);
		apb(1'b0, changeover_pkg::NET_CFG_OFS, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, 8'h14, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		// inputs recover before reset, so every latch must hold alone
		foreach (ROWS[i]) begin
			r = ROWS[i];
			panel_cfg <= r.cfg;
			drive(r);
			tick(2);
			chk(power_lamp, r.perr | ~&r.pon);
			chk(psu_off_lamp ^ r.pon, 32'h3);
			drive(NORM);
			tick(3);
			chk(mfl, r.mf);
			chk(sfl, r.sf);
			chk(alarm_lamp, r.cfg[1] ? r.oe : 9'h0);
			chk(amp_bypass, r.oe);
			chk(flag, r.tr);
			chk(contact, r.tr);
			// the latch words must read back the latches; the alarm word is not masked like the lamps
			apb(1'b0, changeover_pkg::FAULTS_OFS, 32'h0);
			exp_w = 32'(r.sf) << changeover_pkg::FLT_SPARE_POS;
			chk(rd, exp_w | 32'(r.mf));
			apb(1'b0, changeover_pkg::ALARMS_OFS, 32'h0);
			chk(rd, 32'(r.oe));
			press(2);
			chk({mfl, sfl, amp_bypass, flag}, 32'h0);
		end
		// blink: two whole periods give exactly half the cycles lit
		mf <= 11'h400;
		tick(3);
		mf <= 11'h0;
		hi = 0;
		repeat (4 * BH) begin
			tick(1);
			hi += main_sum_lamp;
		end
		chk(hi, 2 * BH);
		chk(spare_sum_lamp, 1'b0);
		chk(mfl, 11'h400);
		apb(1'b1, changeover_pkg::CMD_OFS, 32'h1);
		tick(1);
		chk({mfl, flag}, 12'h0);
		// authority: network settings come back on each return
		apb(1'b1, changeover_pkg::NET_CFG_OFS, 32'h1);
		chk(active_cfg, 2'h2);
		press(0);
		chk(auth_net_lamp, 1'b1);
		chk(active_cfg, 2'h1);
		// panel says fault only, network says fault plus alarm
		perr <= 1'b1;
		tick(1);
		perr <= 1'b0;
		tick(2);
		chk(flag, 1'b1);
		apb(1'b0, changeover_pkg::STATUS_OFS, 32'h0);
		chk(rd[changeover_pkg::ST_AUTH_BIT], 1'b1);
		chk(rd[changeover_pkg::ST_TROUBLE_BIT], 1'b1);
		press(0);
		panel_cfg <= 2'h3;
		tick(1);
		chk(active_cfg, 2'h3);
		press(0);
		chk(active_cfg, 2'h1);
		// second reset in mid-run
		sys_rst <= 1'b1;
		tick(2);
		sys_rst <= 1'b0;
		tick(2);
		chk(auth_net_lamp, 1'b0);
		panel_cfg <= 2'h2;
		// remote source pin: one toggle per low, a short glitch is ignored
		src_on <= 1'b1;
		tick(DB * 5);
		chk({main_sel, spare_sel}, 2'b01);
		src_on <= 1'b0;
		tick(DB * 5);
		src_on <= 1'b1;
		tick(2);
		src_on <= 1'b0;
		tick(DB * 5);
		chk(spare_sel, 1'b1);
		src_on <= 1'b1;
		tick(DB * 5);
		src_on <= 1'b0;
		tick(DB * 5);
		chk({main_sel, spare_sel}, 2'b10);
		// auto switching follows the remote pin only under the panel setting
		panel_auto_en <= 1'b1;
		tick(2);
		chk(auto_active, 1'b1);
		mf <= 11'h001;
		tick(1);
		mf <= 11'h0;
		tick(3);
		chk(spare_sel, 1'b1);
		auto_off <= 1'b1;
		tick(DB * 5);
		chk(auto_active, 1'b0);
		sf <= 11'h001;
		tick(1);
		sf <= 11'h0;
		tick(3);
		chk(spare_sel, 1'b1);
		panel_auto_en <= 1'b0;
		auto_off <= 1'b0;
		tick(DB * 5);
		chk(auto_active, 1'b0);
		// remote reset pin clears the latches
		rst_on <= 1'b1;
		tick(DB * 5);
		rst_on <= 1'b0;
		tick(2);
		chk({mfl, sfl, flag}, 23'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
